//--- logic/ccl_pkg.sv
package ccl_pkg;

  localparam int unsigned NUM_CMP     = 2;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned IDX_W       = 10;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] CTRL0_IDX = 10'h09A;
  localparam logic [IDX_W-1:0] MODE0_IDX = 10'h09B;
  localparam logic [IDX_W-1:0] CTRL1_IDX = 10'h09D;
  localparam logic [IDX_W-1:0] MODE1_IDX = 10'h09E;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h02;

  // control register fields
  localparam int unsigned CTRL_EN_BIT     = 7;
  localparam int unsigned CTRL_RESULT_BIT = 6;
  localparam int unsigned CTRL_RISE_BIT   = 5;
  localparam int unsigned CTRL_FALL_BIT   = 4;
  localparam int unsigned CTRL_POS_LSB    = 2;
  localparam int unsigned CTRL_NEG_LSB    = 0;

  // mode register fields
  localparam int unsigned MODE_RISE_IE_BIT = 5;
  localparam int unsigned MODE_FALL_IE_BIT = 4;
  localparam int unsigned MODE_SEL_LSB     = 0;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CCL_HYST_OFF  = 2'h0,
    CCL_HYST_5MV  = 2'h1,
    CCL_HYST_10MV = 2'h2,
    CCL_HYST_20MV = 2'h3
  } ccl_hyst_t;

  // mode 0 fastest and hungriest, mode 3 slowest and leanest
  typedef enum logic [1:0] {
    CCL_RESP_MODE0 = 2'h0,
    CCL_RESP_MODE1 = 2'h1,
    CCL_RESP_MODE2 = 2'h2,
    CCL_RESP_MODE3 = 2'h3
  } ccl_resp_t;

  function automatic logic [IDX_W-1:0] ccl_ctrl_idx(input logic inst);
    ccl_ctrl_idx = inst ? CTRL1_IDX : CTRL0_IDX;
  endfunction : ccl_ctrl_idx

  function automatic logic [IDX_W-1:0] ccl_mode_idx(input logic inst);
    ccl_mode_idx = inst ? MODE1_IDX : MODE0_IDX;
  endfunction : ccl_mode_idx

endpackage : ccl_pkg

//--- logic/ccl_cmp_if.sv
`timescale 1ns/10ps
interface ccl_cmp_if;
  logic enable;
  logic result;
  logic rise_pulse;
  logic fall_pulse;

  modport top  (output enable, input  result, input  rise_pulse, input  fall_pulse);
  modport chan (input  enable, output result, output rise_pulse, output fall_pulse);
endinterface : ccl_cmp_if

//--- logic/ccl_channel.sv
`timescale 1ns/10ps
module ccl_channel (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // raw comparator decision
  input  wire logic raw_in,
  // towards register logic
  ccl_cmp_if.chan   cmp
);

  logic [ccl_pkg::SYNC_STAGES-1:0] sync_q;
  logic                            result_q;
  logic                            rise_q;
  logic                            fall_q;
  logic                            settled;
  logic                            next_result;

  // a change counts once the last two stages agree
  assign settled     = (sync_q[1] == sync_q[2]);
  assign next_result = cmp.enable & (settled ? sync_q[2] : result_q);

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      sync_q   <= '0;
      result_q <= 1'b0;
      rise_q   <= 1'b0;
      fall_q   <= 1'b0;
    end
    else
    begin
      sync_q   <= {sync_q[1:0], raw_in};
      result_q <= next_result;
      rise_q   <= ~result_q & next_result;
      fall_q   <= result_q & ~next_result;
    end
  end

  assign cmp.result     = result_q;
  assign cmp.rise_pulse = rise_q;
  assign cmp.fall_pulse = fall_q;

endmodule : ccl_channel

//--- logic/ccl_top.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
module ccl_top #(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // analog comparator cores
  input  wire logic [1:0]        cmp_raw_in,
  output logic [1:0]             cmp_power_out,
  output logic [3:0]             cmp_pos_hyst_out,
  output logic [3:0]             cmp_neg_hyst_out,
  output logic [3:0]             cmp_response_mode_out,
  // pin routing and interrupt requests
  output logic [1:0]             cmp_sync_pin_out,
  output logic [1:0]             cmp_async_pin_out,
  output logic [1:0]             cmp_irq_out
);

  localparam int unsigned N = ccl_pkg::NUM_CMP;

  // bus state
  logic                      aw_full;
  logic                      w_full;
  logic [ccl_pkg::IDX_W-1:0] aw_idx;
  logic [7:0]                w_byte;
  logic                      w_lane0;
  logic                      awready;
  logic                      wready;
  logic                      bvalid;
  logic [1:0]                bresp;
  logic                      arready;
  logic                      rvalid;
  logic [1:0]                rresp;
  logic [31:0]               rdata;

  // per comparator state
  logic [N-1:0]              cmp_enable;
  logic [N-1:0]              rise_flag;
  logic [N-1:0]              fall_flag;
  logic [N-1:0]              rise_irq_enable;
  logic [N-1:0]              fall_irq_enable;
  logic [N-1:0]              irq;
  logic [N-1:0]              sync_pin;
  ccl_pkg::ccl_hyst_t        pos_hyst_sel      [N];
  ccl_pkg::ccl_hyst_t        neg_hyst_sel      [N];
  ccl_pkg::ccl_resp_t        response_mode_sel [N];

  // from channels
  logic [N-1:0]              cmp_result;
  logic [N-1:0]              rise_pulse;
  logic [N-1:0]              fall_pulse;

  // decode
  logic                      aw_take;
  logic                      w_take;
  logic                      ar_take;
  logic                      wr_fire;
  logic                      next_aw_full;
  logic                      next_w_full;
  logic                      next_bvalid;
  logic                      next_rvalid;
  logic [ccl_pkg::IDX_W-1:0] ar_idx;
  logic [N-1:0]              ctrl_wr;
  logic [N-1:0]              mode_wr;
  logic [N-1:0]              ctrl_rd_hit;
  logic [N-1:0]              mode_rd_hit;
  logic                      wr_mapped;
  logic                      rd_mapped;
  logic [7:0]                ctrl_view         [N];
  logic [7:0]                mode_view         [N];
  logic [7:0]                rd_byte;
  logic [N-1:0]              aw_hit_ctrl;
  logic [N-1:0]              aw_hit_mode;

  assign aw_take      = s_axi_awvalid_in & awready;
  assign w_take       = s_axi_wvalid_in & wready;
  assign ar_take      = s_axi_arvalid_in & arready;
  // address and data may arrive in either order; response follows both
  assign wr_fire      = aw_full & w_full & ~bvalid;
  assign next_aw_full = (aw_full | aw_take) & ~wr_fire;
  assign next_w_full  = (w_full | w_take) & ~wr_fire;
  assign next_bvalid  = wr_fire | (bvalid & ~s_axi_bready_in);
  assign next_rvalid  = ar_take | (rvalid & ~s_axi_rready_in);
  assign ar_idx       = s_axi_araddr_in[ccl_pkg::IDX_W+1:2];
  assign wr_mapped    = |{ctrl_wr, mode_wr} | (aw_full & |{aw_hit_ctrl, aw_hit_mode});
  assign rd_mapped    = |{ctrl_rd_hit, mode_rd_hit};

  // write handshake state
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= ccl_pkg::AXI_OKAY;
    end
    else
    begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      awready <= ~next_aw_full;
      wready  <= ~next_w_full;
      bvalid  <= next_bvalid;
      if (wr_fire)
        bresp <= wr_mapped ? ccl_pkg::AXI_OKAY : ccl_pkg::AXI_SLVERR;
    end
  end

  // captured write address and data byte
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      aw_idx  <= '0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end
    else
    begin
      if (aw_take)
        aw_idx <= s_axi_awaddr_in[ccl_pkg::IDX_W+1:2];
      if (w_take)
      begin
        w_byte  <= s_axi_wdata_in[7:0];
        w_lane0 <= s_axi_wstrb_in[0];
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= ccl_pkg::AXI_OKAY;
      rdata   <= 32'h0000_0000;
    end
    else
    begin
      arready <= ~next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_take)
      begin
        rresp <= rd_mapped ? ccl_pkg::AXI_OKAY : ccl_pkg::AXI_SLVERR;
        rdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // read mux over both register pairs; unmapped reads zero
  always_comb
  begin
    rd_byte = 8'h00;
    for (int k = 0; k < N; k++)
    begin
      if (ctrl_rd_hit[k])
        rd_byte = ctrl_view[k];
      if (mode_rd_hit[k])
        rd_byte = mode_view[k];
    end
  end

  for (genvar i = 0; i < N; i++)
  begin : g_cmp
    ccl_cmp_if cif ();

    logic next_rise;
    logic next_fall;

    assign aw_hit_ctrl[i]    = (aw_idx == ccl_pkg::ccl_ctrl_idx(1'(i)));
    assign aw_hit_mode[i]    = (aw_idx == ccl_pkg::ccl_mode_idx(1'(i)));
    assign ctrl_wr[i]        = wr_fire & w_lane0 & aw_hit_ctrl[i];
    assign mode_wr[i]        = wr_fire & w_lane0 & aw_hit_mode[i];
    assign ctrl_rd_hit[i]    = (ar_idx == ccl_pkg::ccl_ctrl_idx(1'(i)));
    assign mode_rd_hit[i]    = (ar_idx == ccl_pkg::ccl_mode_idx(1'(i)));

    assign cif.enable    = cmp_enable[i];
    assign cmp_result[i] = cif.result;
    assign rise_pulse[i] = cif.rise_pulse;
    assign fall_pulse[i] = cif.fall_pulse;

    assign next_rise = (ctrl_wr[i] ? w_byte[ccl_pkg::CTRL_RISE_BIT] : rise_flag[i])
                       | rise_pulse[i];
    assign next_fall = (ctrl_wr[i] ? w_byte[ccl_pkg::CTRL_FALL_BIT] : fall_flag[i])
                       | fall_pulse[i];

    assign ctrl_view[i] = {cmp_enable[i], cmp_result[i], rise_flag[i], fall_flag[i],
                           pos_hyst_sel[i], neg_hyst_sel[i]};
    assign mode_view[i] = {2'b00, rise_irq_enable[i], fall_irq_enable[i], 2'b00,
                           response_mode_sel[i]};

    ccl_channel u_chan (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .raw_in  (cmp_raw_in[i]),
      .cmp     (cif.chan)
    );

    // sticky edge flags
    always_ff @(posedge clk_in)
    begin
      if (!rstn_in)
      begin
        rise_flag[i] <= ccl_pkg::CTRL_RESET[ccl_pkg::CTRL_RISE_BIT];
        fall_flag[i] <= ccl_pkg::CTRL_RESET[ccl_pkg::CTRL_FALL_BIT];
      end
      else
      begin
        fall_flag[i] <= next_fall;
        rise_flag[i] <= next_rise;
      end
    end

    // control register fields
    always_ff @(posedge clk_in)
    begin
      if (!rstn_in)
      begin
        cmp_enable[i]   <= ccl_pkg::CTRL_RESET[ccl_pkg::CTRL_EN_BIT];
        pos_hyst_sel[i] <= ccl_pkg::ccl_hyst_t'(
                           ccl_pkg::CTRL_RESET[ccl_pkg::CTRL_POS_LSB +: 2]);
        neg_hyst_sel[i] <= ccl_pkg::ccl_hyst_t'(
                           ccl_pkg::CTRL_RESET[ccl_pkg::CTRL_NEG_LSB +: 2]);
      end
      else if (ctrl_wr[i])
      begin
        cmp_enable[i]   <= w_byte[ccl_pkg::CTRL_EN_BIT];
        pos_hyst_sel[i] <= ccl_pkg::ccl_hyst_t'(w_byte[ccl_pkg::CTRL_POS_LSB +: 2]);
        neg_hyst_sel[i] <= ccl_pkg::ccl_hyst_t'(w_byte[ccl_pkg::CTRL_NEG_LSB +: 2]);
      end
    end

    // mode register fields
    always_ff @(posedge clk_in)
    begin
      if (!rstn_in)
      begin
        rise_irq_enable[i]   <= ccl_pkg::MODE_RESET[ccl_pkg::MODE_RISE_IE_BIT];
        fall_irq_enable[i]   <= ccl_pkg::MODE_RESET[ccl_pkg::MODE_FALL_IE_BIT];
        response_mode_sel[i] <= ccl_pkg::ccl_resp_t'(
                                ccl_pkg::MODE_RESET[ccl_pkg::MODE_SEL_LSB +: 2]);
      end
      else if (mode_wr[i])
      begin
        rise_irq_enable[i]   <= w_byte[ccl_pkg::MODE_RISE_IE_BIT];
        fall_irq_enable[i]   <= w_byte[ccl_pkg::MODE_FALL_IE_BIT];
        response_mode_sel[i] <= ccl_pkg::ccl_resp_t'(w_byte[ccl_pkg::MODE_SEL_LSB +: 2]);
      end
    end

    // request and clocked pin copy
    always_ff @(posedge clk_in)
    begin
      if (!rstn_in)
      begin
        irq[i]      <= 1'b0;
        sync_pin[i] <= 1'b0;
      end
      else
      begin
        irq[i]      <= (rise_flag[i] & rise_irq_enable[i]) |
                       (fall_flag[i] & fall_irq_enable[i]);
        sync_pin[i] <= cmp_result[i];
      end
    end

    // raw path bypasses the clock so it runs with the clock stopped
    assign cmp_async_pin_out[i] = cmp_raw_in[i] & cmp_enable[i];

    assign cmp_pos_hyst_out[2*i +: 2]      = pos_hyst_sel[i];
    assign cmp_neg_hyst_out[2*i +: 2]      = neg_hyst_sel[i];
    assign cmp_response_mode_out[2*i +: 2] = response_mode_sel[i];
  end

  assign cmp_power_out     = cmp_enable;
  // poll, interrupt and pin paths side by side
  assign cmp_sync_pin_out  = sync_pin;
  assign cmp_irq_out       = irq;

  assign s_axi_awready_out = awready;
  assign s_axi_wready_out  = wready;
  assign s_axi_bvalid_out  = bvalid;
  assign s_axi_bresp_out   = bresp;
  assign s_axi_arready_out = arready;
  assign s_axi_rvalid_out  = rvalid;
  assign s_axi_rresp_out   = rresp;
  assign s_axi_rdata_out   = rdata;

endmodule : ccl_top

//--- tb/ccl_assertions.sv
`timescale 1ns/10ps
module ccl_checker (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // bus handshakes
  input  wire logic        s_axi_arvalid_in,
  input  wire logic        s_axi_arready_out,
  input  wire logic        s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic [31:0] s_axi_rdata_out,
  input  wire logic        s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // comparator side
  input  wire logic [1:0]  cmp_raw_in,
  input  wire logic [1:0]  cmp_power_out,
  input  wire logic [3:0]  cmp_pos_hyst_out,
  input  wire logic [3:0]  cmp_neg_hyst_out,
  input  wire logic [3:0]  cmp_response_mode_out,
  input  wire logic [1:0]  cmp_sync_pin_out,
  input  wire logic [1:0]  cmp_async_pin_out,
  input  wire logic [1:0]  cmp_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_async_pin_gated: assert property (cmp_async_pin_out == (cmp_raw_in & cmp_power_out))
    else $error("raw pin output not gated by enable");
  a_sync_pin_off: assert property ((!cmp_power_out[0]) [*4] |-> !cmp_sync_pin_out[0])
    else $error("clocked pin output high while disabled");
  a_config_by_write: assert property (!$stable({cmp_pos_hyst_out, cmp_neg_hyst_out,
      cmp_response_mode_out, cmp_power_out}) |-> s_axi_bvalid_out)
    else $error("settings changed without a write");
  a_irq_drop_write: assert property ($fell(cmp_irq_out[0]) |-> $past(s_axi_bvalid_out))
    else $error("request dropped without a write");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered next cycle");
  a_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data not held");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response not held");
  a_read_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("second read accepted");

  c_irq_rise: cover property ($rose(cmp_irq_out[0]));
  c_read_done: cover property (s_axi_rvalid_out && s_axi_rready_in);
  c_write_done: cover property (s_axi_bvalid_out && s_axi_bready_in);
endmodule : ccl_checker

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clk_in           = 1'b0;
  logic        rstn_in          = 1'b0;
  logic [11:0] s_axi_awaddr_in  = 12'h000;
  logic        s_axi_awvalid_in = 1'b0;
  logic [31:0] s_axi_wdata_in   = 32'h00000000;
  logic [3:0]  s_axi_wstrb_in   = 4'h0;
  logic        s_axi_wvalid_in  = 1'b0;
  logic        s_axi_bready_in  = 1'b0;
  logic [11:0] s_axi_araddr_in  = 12'h000;
  logic        s_axi_arvalid_in = 1'b0;
  logic        s_axi_rready_in  = 1'b0;
  logic [1:0]  cmp_raw_in       = 2'h0;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic [1:0]  cmp_power_out, cmp_sync_pin_out, cmp_async_pin_out, cmp_irq_out;
  logic [3:0]  cmp_pos_hyst_out, cmp_neg_hyst_out, cmp_response_mode_out;
  int          fails       = 0;
  int          check_count = 0;

  ccl_top #(.ADDR_W(12)) DUT (.*);

  always #12.5 clk_in = ~clk_in;

  task automatic print_verdict;
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic to_chk(input int n);
    if (n >= 50)
    begin
      fails++;
      print_verdict();
    end
  endtask : to_chk

  task automatic idle(input int k);
    repeat (k) @(posedge clk_in);
  endtask : idle

  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int   n;
    logic aw;
    logic w;
    aw = 1'b1;
    w  = 1'b1;
    s_axi_awaddr_in  <= {a, 2'h0};
    s_axi_wdata_in   <= {24'h000000, d};
    s_axi_wstrb_in   <= s;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in  <= 1'b1;
    for (n = 0; n < 50 && (aw || w); n++)
    begin
      @(posedge clk_in);
      aw = aw && !s_axi_awready_out;
      w  = w && !s_axi_wready_out;
      s_axi_awvalid_in <= aw;
      s_axi_wvalid_in  <= w;
    end
    to_chk(n);
    for (n = 0; n < 50 && !s_axi_bvalid_out; n++) @(posedge clk_in);
    to_chk(n);
    chk8({6'h00, s_axi_bresp_out}, {6'h00, er});
    s_axi_bready_in <= 1'b1;
    @(posedge clk_in);
    s_axi_bready_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    s_axi_araddr_in  <= {a, 2'h0};
    s_axi_arvalid_in <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_in);
      if (s_axi_arready_out === 1'b1) break;
    end
    to_chk(n);
    s_axi_arvalid_in <= 1'b0;
    for (n = 0; n < 50 && !s_axi_rvalid_out; n++) @(posedge clk_in);
    to_chk(n);
    chk8({6'h00, s_axi_rresp_out}, {6'h00, er});
    chk8(s_axi_rdata_out[7:0], e);
    s_axi_rready_in <= 1'b1;
    @(posedge clk_in);
    s_axi_rready_in <= 1'b0;
  endtask : rd

  initial
  begin
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd(ccl_pkg::CTRL0_IDX, 8'h00, ccl_pkg::AXI_OKAY);
    rd(ccl_pkg::MODE0_IDX, 8'h02, ccl_pkg::AXI_OKAY);
    rd(ccl_pkg::CTRL1_IDX, 8'h00, ccl_pkg::AXI_OKAY);
    rd(ccl_pkg::MODE1_IDX, 8'h02, ccl_pkg::AXI_OKAY);
    chk8({4'h0, cmp_response_mode_out}, 8'h0A);
    chk8({6'h00, cmp_power_out}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(ccl_pkg::MODE0_IDX, 8'hCC | 8'(i), 4'h1, ccl_pkg::AXI_OKAY);
      rd(ccl_pkg::MODE0_IDX, 8'(i), ccl_pkg::AXI_OKAY);
      wr(ccl_pkg::CTRL0_IDX, {4'h0, i[1:0], ~i[1:0]}, 4'h1, ccl_pkg::AXI_OKAY);
      chk8({6'h00, cmp_response_mode_out[1:0]}, 8'(i));
      chk8({4'h0, cmp_pos_hyst_out[1:0], cmp_neg_hyst_out[1:0]},
           {4'h0, i[1:0], ~i[1:0]});
    end
    // unmapped slot and a write with no byte lane
    wr(10'h09C, 8'h55, 4'h1, ccl_pkg::AXI_SLVERR);
    rd(10'h09C, 8'h00, ccl_pkg::AXI_SLVERR);
    wr(ccl_pkg::MODE0_IDX, 8'h30, 4'h0, ccl_pkg::AXI_OKAY);
    rd(ccl_pkg::MODE0_IDX, 8'h03, ccl_pkg::AXI_OKAY);
    wr(ccl_pkg::MODE0_IDX, 8'h00, 4'h1, ccl_pkg::AXI_OKAY);
    wr(ccl_pkg::CTRL0_IDX, 8'h80, 4'h1, ccl_pkg::AXI_OKAY);
    chk8({6'h00, cmp_power_out}, 8'h01);
    cmp_raw_in <= 2'b01;
    idle(8);
    rd(ccl_pkg::CTRL0_IDX, 8'hE0, ccl_pkg::AXI_OKAY);
    chk8({2'h0, cmp_sync_pin_out, cmp_async_pin_out, cmp_irq_out}, 8'h14);
    wr(ccl_pkg::MODE0_IDX, 8'h20, 4'h1, ccl_pkg::AXI_OKAY);
    idle(3);
    chk8({6'h00, cmp_irq_out}, 8'h01);
    wr(ccl_pkg::MODE0_IDX, 8'h10, 4'h1, ccl_pkg::AXI_OKAY);
    idle(3);
    chk8({6'h00, cmp_irq_out}, 8'h00);
    cmp_raw_in <= 2'b00;
    idle(8);
    rd(ccl_pkg::CTRL0_IDX, 8'hB0, ccl_pkg::AXI_OKAY);
    chk8({6'h00, cmp_irq_out}, 8'h01);
    wr(ccl_pkg::CTRL0_IDX, 8'h80, 4'h1, ccl_pkg::AXI_OKAY);
    idle(3);
    rd(ccl_pkg::CTRL0_IDX, 8'h80, ccl_pkg::AXI_OKAY);
    chk8({6'h00, cmp_irq_out}, 8'h00);
    cmp_raw_in <= 2'b11;
    idle(8);
    wr(ccl_pkg::CTRL0_IDX, 8'h00, 4'h1, ccl_pkg::AXI_OKAY);
    idle(4);
    chk8({2'h0, cmp_power_out, cmp_sync_pin_out, cmp_async_pin_out}, 8'h00);
    wr(ccl_pkg::CTRL1_IDX, 8'h80, 4'h1, ccl_pkg::AXI_OKAY);
    idle(8);
    rd(ccl_pkg::CTRL1_IDX, 8'hE0, ccl_pkg::AXI_OKAY);
    chk8({4'h0, cmp_sync_pin_out, cmp_async_pin_out}, 8'h0A);
    wr(ccl_pkg::MODE1_IDX, 8'hFF, 4'h1, ccl_pkg::AXI_OKAY);
    rd(ccl_pkg::MODE1_IDX, 8'h33, ccl_pkg::AXI_OKAY);
    chk8({4'h0, cmp_response_mode_out}, 8'h0C);
    chk8({6'h00, cmp_irq_out}, 8'h03);
    print_verdict();
  end
endmodule : tb_top

bind ccl_top ccl_checker u_chk (.clk_in, .rstn_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .cmp_raw_in, .cmp_power_out, .cmp_pos_hyst_out, .cmp_neg_hyst_out, .cmp_response_mode_out,
  .cmp_sync_pin_out, .cmp_async_pin_out, .cmp_irq_out);
